//--- rtl/ssx_exec.sv
// Execution slice: stop, subtract, nibble swap, mask tests.
// Sequencer hands one decoded instruction with fetched operands per
// strobe; the result and flags go back to the register file.
// How it works
// - Stop opcode 7F halts CPU and system clocks, flags untouched.
// - While stopped no register, flag or port write leaves this block.
// - Only external reset or external interrupt ends the stopped state.
// - Subtract stores dst minus src via two's complement; 4 or 6 cycles.
// - Subtract: C is borrow, Z zero, S negative, V signed overflow.
// - Subtract forces D to one; H set on nibble borrow.
// - Swap exchanges nibbles in 4 cycles; Z,S from result; D,H kept.
// - Complement mask test sets Z,S from ~dst&src, clears V, no write.
// - Mask test sets Z,S from dst&src, clears V, no write.
`timescale 1ns/10ps
module ssx_exec #(
  parameter int unsigned W = ssx_pkg::DATA_W
) (
  input  wire logic         I_CLK_SYS,   // CPU clock
  input  wire logic         I_NRST,      // Sync reset, active low
  input  wire logic         i_start,     // Instruction valid pulse
  input  wire logic [7:0]   i_opcode,    // Opcode byte
  input  wire logic [W-1:0] i_dst,       // Destination operand
  input  wire logic [W-1:0] i_src,       // Source operand or mask
  input  wire logic         i_ext_irq,   // External interrupt request
  output logic              o_busy,      // Instruction executing
  output logic              o_done,      // Pulse in the cycle after the last busy cycle
  output logic              o_known,     // Opcode handled by this slice
  output logic [1:0]        o_len,       // Instruction length, bytes
  output logic [2:0]        o_cycles,    // Execution cycles
  output logic              o_wr_en,     // Write result to destination
  output logic [W-1:0]      o_result,    // Result value
  output logic [7:0]        o_flags,     // Flag register
  output logic              o_clk_run,   // CPU and system clock enable
  output logic              o_stopped    // In stopped state
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STOP} ssx_state_e;

  ssx_state_e       state_q;
  ssx_pkg::ssx_op_e op_kind, op_q;
  logic [2:0]       cyc_need, cnt_q;
  logic [1:0]       len_d;
  logic [W-1:0]     dst_q, src_q, alu_res;
  logic [7:0]       flags_q, alu_flags;
  logic             alu_wr, last;

  // Decode kind, length and cycle count
  always_comb begin
    op_kind  = ssx_pkg::OPK_NONE;
    len_d    = ssx_pkg::LEN_THREE;
    cyc_need = ssx_pkg::CYC_LONG;
    if (i_opcode == ssx_pkg::OP_STOP) begin
      op_kind  = ssx_pkg::OPK_STOP;
      len_d    = ssx_pkg::LEN_ONE;
      cyc_need = ssx_pkg::CYC_SHORT;
    end else if (i_opcode == ssx_pkg::OP_SWAP_R ||
                 i_opcode == ssx_pkg::OP_SWAP_IR) begin
      op_kind  = ssx_pkg::OPK_SWAP;
      len_d    = ssx_pkg::LEN_TWO;
      cyc_need = ssx_pkg::CYC_SHORT;
    end else begin
      if (i_opcode >= ssx_pkg::OP_SUB_FIRST &&
          i_opcode <= ssx_pkg::OP_SUB_LAST)
        op_kind = ssx_pkg::OPK_SUB;
      else if (i_opcode >= ssx_pkg::OP_TSTC_FIRST &&
               i_opcode <= ssx_pkg::OP_TSTC_LAST)
        op_kind = ssx_pkg::OPK_TSTC;
      else if (i_opcode >= ssx_pkg::OP_TSTM_FIRST &&
               i_opcode <= ssx_pkg::OP_TSTM_LAST)
        op_kind = ssx_pkg::OPK_TSTM;
      if (i_opcode[3:0] == ssx_pkg::LO_WORK_RR ||
          i_opcode[3:0] == ssx_pkg::LO_WORK_RIR)
        len_d = ssx_pkg::LEN_TWO;
      if (i_opcode[3:0] == ssx_pkg::LO_WORK_RR)
        cyc_need = ssx_pkg::CYC_SHORT;
    end
  end

  assign o_known = (op_kind != ssx_pkg::OPK_NONE);
  assign last    = (state_q == ST_EXEC) && (cnt_q == 3'h1);

  // Sequencing and stop state
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      op_q    <= ssx_pkg::OPK_NONE;
    end else begin
      case (state_q)
        ST_IDLE: if (i_start && o_known) begin
          state_q <= ST_EXEC;
          cnt_q   <= cyc_need;
          op_q    <= op_kind;
        end
        ST_EXEC: begin
          cnt_q <= cnt_q - 3'h1;
          if (last)
            state_q <= (op_q == ssx_pkg::OPK_STOP) ? ST_STOP : ST_IDLE;
        end
        ST_STOP: if (i_ext_irq) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Operand capture
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      dst_q <= '0;
      src_q <= '0;
    end else if (state_q == ST_IDLE && i_start && o_known) begin
      dst_q <= i_dst;
      src_q <= i_src;
    end
  end

  ssx_alu #(.W(W)) u_alu (
    .i_op    (op_q),
    .i_dst   (dst_q),
    .i_src   (src_q),
    .i_flags (flags_q),
    .o_res   (alu_res),
    .o_flags (alu_flags),
    .o_wr    (alu_wr)
  );

  // Flag register and result outputs
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      flags_q  <= ssx_pkg::FLAGS_RESET;
      o_result <= '0;
      o_wr_en  <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done  <= last;
      o_wr_en <= last && alu_wr;
      if (last && op_q != ssx_pkg::OPK_STOP) begin
        flags_q  <= alu_flags;
        o_result <= alu_res;
      end
      // Stop and stopped state leave flags alone
    end
  end

  // Length and cycle info held for the sequencer
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      o_len    <= ssx_pkg::LEN_ONE;
      o_cycles <= ssx_pkg::CYC_SHORT;
    end else if (state_q == ST_IDLE && i_start && o_known) begin
      o_len    <= len_d;
      o_cycles <= cyc_need;
    end
  end

  assign o_flags   = flags_q;
  assign o_busy    = (state_q == ST_EXEC);
  assign o_stopped = (state_q == ST_STOP);
  assign o_clk_run = (state_q != ST_STOP);
endmodule : ssx_exec

//--- rtl/ssx_pkg.sv
// Package for the stop/subtract/swap/test-mask execution slice.
// Shared by the datapath top and its ALU leaf; no imports expected.
package ssx_pkg;
  localparam int unsigned DATA_W       = 8;
  // Opcodes
  localparam logic [7:0] OP_STOP       = 8'h7F;
  localparam logic [7:0] OP_SUB_FIRST  = 8'h22;
  localparam logic [7:0] OP_SUB_LAST   = 8'h26;
  localparam logic [7:0] OP_SWAP_R     = 8'hF0;
  localparam logic [7:0] OP_SWAP_IR    = 8'hF1;
  localparam logic [7:0] OP_TSTC_FIRST = 8'h62;
  localparam logic [7:0] OP_TSTC_LAST  = 8'h66;
  localparam logic [7:0] OP_TSTM_FIRST = 8'h72;
  localparam logic [7:0] OP_TSTM_LAST  = 8'h76;
  // Low nibble of the two working-register forms
  localparam logic [3:0] LO_WORK_RR    = 4'h2;
  localparam logic [3:0] LO_WORK_RIR   = 4'h3;
  // Lengths in bytes and cycles
  localparam logic [1:0] LEN_ONE       = 2'h1;
  localparam logic [1:0] LEN_TWO       = 2'h2;
  localparam logic [1:0] LEN_THREE     = 2'h3;
  localparam logic [2:0] CYC_SHORT     = 3'h4;
  localparam logic [2:0] CYC_LONG      = 3'h6;
  // Flag register bit positions
  localparam int unsigned FLG_C        = 7;
  localparam int unsigned FLG_Z        = 6;
  localparam int unsigned FLG_S        = 5;
  localparam int unsigned FLG_V        = 4;
  localparam int unsigned FLG_D        = 3;
  localparam int unsigned FLG_H        = 2;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;

  typedef enum logic [2:0] {
    OPK_NONE, OPK_STOP, OPK_SUB, OPK_SWAP, OPK_TSTC, OPK_TSTM
  } ssx_op_e;
endpackage : ssx_pkg

//--- rtl/ssx_alu.sv
// Combinational ALU for subtract, nibble swap and the two mask tests.
// Assumes operands are already fetched; flags in the package layout.
`timescale 1ns/10ps
module ssx_alu #(
  parameter int unsigned W = ssx_pkg::DATA_W
) (
  input  wire ssx_pkg::ssx_op_e i_op,     // Operation kind
  input  wire logic [W-1:0]     i_dst,    // Destination operand
  input  wire logic [W-1:0]     i_src,    // Source operand or mask
  input  wire logic [7:0]       i_flags,  // Current flag register
  output logic [W-1:0]          o_res,    // Result value
  output logic [7:0]            o_flags,  // Updated flag register
  output logic                  o_wr      // Result goes to destination
);
  logic [W:0]   sum;
  logic [4:0]   lo_sum;
  logic [W-1:0] val;

  always_comb begin
    // Two's complement add; carry out means no borrow
    sum    = {1'b0, i_dst} + {1'b0, ~i_src} + {{W{1'b0}}, 1'b1};
    lo_sum = {1'b0, i_dst[3:0]} + {1'b0, ~i_src[3:0]} + 5'h01;
    val    = '0;
    o_flags = i_flags;
    o_wr    = 1'b0;
    case (i_op)
      ssx_pkg::OPK_SUB: begin
        val = sum[W-1:0];
        o_wr = 1'b1;
        o_flags[ssx_pkg::FLG_C] = ~sum[W];
        o_flags[ssx_pkg::FLG_V] = (i_dst[W-1] ^ i_src[W-1]) &
                                  (val[W-1] == i_src[W-1]);
        o_flags[ssx_pkg::FLG_D] = 1'b1;
        o_flags[ssx_pkg::FLG_H] = ~lo_sum[4];
      end
      ssx_pkg::OPK_SWAP: begin
        val = {i_dst[3:0], i_dst[W-1:4]};
        o_wr = 1'b1;
        // Carry and overflow are undefined; left as they were
      end
      ssx_pkg::OPK_TSTC: begin
        val = ~i_dst & i_src;
        o_flags[ssx_pkg::FLG_V] = 1'b0;
      end
      ssx_pkg::OPK_TSTM: begin
        val = i_dst & i_src;
        o_flags[ssx_pkg::FLG_V] = 1'b0;
      end
      default: val = '0;
    endcase
    if (i_op == ssx_pkg::OPK_SUB || i_op == ssx_pkg::OPK_SWAP ||
        i_op == ssx_pkg::OPK_TSTC || i_op == ssx_pkg::OPK_TSTM) begin
      o_flags[ssx_pkg::FLG_Z] = (val == '0);
      o_flags[ssx_pkg::FLG_S] = val[W-1];
    end
    o_res = val;
  end
endmodule : ssx_alu

//--- testbench/ssx_exec_properties.sv
// Checker for the execution slice: timing, flags, stop.
// Bound to ssx_exec; sees its ports only.
`timescale 1ns/10ps
module ssx_exec_chk (
  input wire logic       I_CLK_SYS, // Clock
  input wire logic       I_NRST,    // Reset
  input wire logic       i_start,   // Start
  input wire logic [7:0] i_opcode,  // Opcode
  input wire logic       i_ext_irq, // Wake
  input wire logic       o_busy,    // Busy
  input wire logic       o_done,    // Done
  input wire logic       o_known,   // Known
  input wire logic [1:0] o_len,     // Length
  input wire logic       o_wr_en,   // Write
  input wire logic [7:0] o_flags,   // Flags
  input wire logic       o_clk_run, // Clock on
  input wire logic       o_stopped  // Stopped
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  logic [7:0] op_q;
  wire take = i_start && o_known && !o_busy && !o_stopped;
  always_ff @(posedge I_CLK_SYS) begin
    if (take) op_q <= i_opcode;
  end
  sequence s_take;
    take;
  endsequence
  a_short_done: assert property (
    s_take ##0 (i_opcode[3:0] == 4'h2 || i_opcode[7:4] == 4'hF) |->
    ##5 o_done) else $error("short op done late");
  a_long_done: assert property (
    s_take ##0 (i_opcode[7:4] != 4'hF && i_opcode[3:0] > 4'h2 &&
    i_opcode != 8'h7F) |=> !o_done[*6] ##1 o_done)
    else $error("long op done wrong");
  a_stop_enter: assert property (
    s_take ##0 (i_opcode == 8'h7F) |-> ##5 (o_stopped && !o_clk_run))
    else $error("no stop");
  a_stop_hold: assert property (
    o_stopped && !i_ext_irq |=> o_stopped && $stable(o_flags) &&
    !o_wr_en) else $error("stop lost");
  a_irq_wake: assert property (
    o_stopped && i_ext_irq |=> !o_stopped && o_clk_run)
    else $error("no wake");
  a_sub_dflag: assert property (
    o_done && op_q[7:4] == 4'h2 |-> o_flags[3] && o_wr_en)
    else $error("sub flags");
  a_test_nowr: assert property (
    o_done && op_q[7:5] == 3'h3 && op_q != 8'h7F |-> !o_wr_en &&
    !o_flags[4]) else $error("test wrote");
  a_len_decode: assert property (
    s_take ##0 ((i_opcode[7:5] == 3'h1 || i_opcode[7:5] == 3'h3) &&
    i_opcode != 8'h7F) |=> o_len == ((($past(i_opcode) & 8'h0E) ==
    8'h02) ? 2'h2 : 2'h3)) else $error("length");
  a_swap_keep: assert property (
    o_done && op_q[7:4] == 4'hF |->
    (o_flags & 8'h0C) == ($past(o_flags) & 8'h0C))
    else $error("swap D H");
endmodule : ssx_exec_chk
bind ssx_exec ssx_exec_chk u_chk (.I_CLK_SYS, .I_NRST, .i_start, .i_opcode,
  .i_ext_irq, .o_busy, .o_done, .o_known, .o_len, .o_wr_en, .o_flags,
  .o_clk_run, .o_stopped);

//--- testbench/ssx_rf_model.sv
// Register file stand-in: keeps written byte and write count.
// Assumes the write strobe is a one-cycle pulse.
`timescale 1ns/10ps
module ssx_rf_model (
  input  wire logic       i_clk,    // Clock
  input  wire logic       i_nrst,   // Sync reset
  input  wire logic       i_wr_en,  // Write strobe
  input  wire logic [7:0] i_result, // Result
  output logic [7:0]      o_dst,    // Stored byte
  output logic [7:0]      o_wr_cnt  // Writes seen
);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wr_cnt <= 8'h00;
    end else if (i_wr_en) begin
      o_dst    <= i_result;
      o_wr_cnt <= o_wr_cnt + 8'h01;
    end
  end
endmodule : ssx_rf_model

//--- testbench/tb_top.sv
// Bench for the execution slice: op table, stop, wake, reset.
// Bench acts as sequencer; model records register writes.
`timescale 1ns/10ps
module tb_top;
  logic       I_CLK_SYS = 1'b0, I_NRST = 1'b0, i_start = 1'b0;
  logic       i_ext_irq = 1'b0;
  logic [7:0] i_opcode = 8'h00, i_dst = 8'h00, i_src = 8'h00;
  logic       o_busy, o_done, o_known, o_wr_en, o_clk_run, o_stopped;
  logic [1:0] o_len;
  logic [2:0] o_cycles;
  logic [7:0] o_result, o_flags, rf_dst, rf_cnt, exp_wr = 8'h00;
  int         bad_count = 0, num_checks = 0, cyc = 0;
  // Opcode, dst, src, result, flags
  logic [39:0] tab [17] = '{40'h22_12_03_0F_0C, 40'h26_21_90_91_B8,
    40'h64_2B_23_00_C8, 40'h24_21_65_BC_AC, 40'h76_2B_54_00_CC,
    40'hF1_3E_00_E3_AC, 40'h23_05_05_00_48, 40'h72_C7_02_02_08,
    40'h62_C7_02_00_48, 40'h25_00_01_FF_AC, 40'hF0_00_00_00_CC,
    40'h63_2B_80_80_AC, 40'h65_FF_FF_00_CC, 40'h66_00_7F_7F_8C,
    40'h73_F0_0F_00_CC, 40'h74_80_80_80_AC, 40'h75_2B_23_23_8C};
  ssx_exec u_ssx_exec (.I_CLK_SYS, .I_NRST, .i_start, .i_opcode, .i_dst,
    .i_src, .i_ext_irq, .o_busy, .o_done, .o_known, .o_len, .o_cycles,
    .o_wr_en, .o_result, .o_flags, .o_clk_run, .o_stopped);
  ssx_rf_model u_ssx_rf_model (.i_clk(I_CLK_SYS), .i_nrst(I_NRST),
    .i_wr_en(o_wr_en), .i_result(o_result), .o_dst(rf_dst), .o_wr_cnt(rf_cnt));
  always #2.5 I_CLK_SYS = ~I_CLK_SYS;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  always @(posedge I_CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Returns at the take edge
  task automatic issue(input logic [7:0] op, d, s);
    @(posedge I_CLK_SYS);
    i_start  <= 1'b1;
    i_opcode <= op;
    i_dst    <= d;
    i_src    <= s;
    @(posedge I_CLK_SYS);
    i_start  <= 1'b0;
  endtask : issue
  task automatic run(input logic [39:0] e);
    int         n;
    int         b;
    logic [7:0] op;
    logic       wr, sh;
    n  = 0;
    b  = 0;
    op = e[39:32];
    wr = (op[7:4] == 4'h2) || (op[7:4] == 4'hF);
    sh = (op[7:4] == 4'hF) || (op[3:0] == 4'h2);
    issue(op, e[31:24], e[23:16]);
    while (o_done !== 1'b1 && n < 20) begin
      @(negedge I_CLK_SYS);
      n++;
      b += int'(o_busy);
    end
    chk(8'(n), sh ? 8'h05 : 8'h07);
    chk(8'(b), sh ? 8'h04 : 8'h06);
    chk({5'h00, o_cycles}, sh ? 8'h04 : 8'h06);
    chk({6'h00, o_len}, (op[7:4] == 4'hF || op[3:1] == 3'h1) ? 8'h02 : 8'h03);
    chk(o_result, e[15:8]);
    chk(o_flags, e[7:0]);
    chk({7'h00, o_wr_en}, {7'h00, wr});
    exp_wr += {7'h00, wr};
  endtask : run
  initial begin
    repeat (16) @(posedge I_CLK_SYS);
    I_NRST <= 1'b1;
    chk(o_flags, 8'h00);
    foreach (tab[i]) begin
      run(tab[i]);
    end
    issue(8'h7F, 8'h00, 8'h00);
    repeat (6) @(negedge I_CLK_SYS);
    chk({6'h00, o_stopped, o_clk_run}, 8'h02);
    issue(8'h22, 8'h40, 8'h01);
    repeat (8) @(negedge I_CLK_SYS);
    chk({6'h00, o_stopped, o_clk_run}, 8'h02);
    chk(o_flags, 8'h8C);
    @(posedge I_CLK_SYS);
    i_ext_irq <= 1'b1;
    @(posedge I_CLK_SYS);
    i_ext_irq <= 1'b0;
    @(negedge I_CLK_SYS);
    chk({6'h00, o_stopped, o_clk_run}, 8'h01);
    run(40'h26_05_01_04_08);
    @(negedge I_CLK_SYS);
    chk(rf_cnt, exp_wr);
    chk(rf_dst, 8'h04);
    issue(8'h27, 8'h01, 8'h01);
    @(negedge I_CLK_SYS);
    chk({6'h00, o_known, o_busy}, 8'h00);
    issue(8'h7F, 8'h00, 8'h00);
    repeat (6) @(negedge I_CLK_SYS);
    @(posedge I_CLK_SYS);
    I_NRST <= 1'b0;
    repeat (2) @(negedge I_CLK_SYS);
    chk({o_flags[7:1], o_stopped}, 8'h00);
    test_done();
  end
endmodule : tb_top
